// File: verilog/ulst_top.v
// user logic steps with timers, routed logic outputs and terminal selection
`timescale 1ns/100ps
`include "ulst_defs.vh"

// Summary of operation
// - each step has a timer type, 0 none through 5 pulse train, reset to 0.
// - on-delay: output asserts once the period elapsed with the input held.
// - on-delay: input dropping clears the output and abandons the delay.
// - off-delay: output asserts at once when the input asserts.
// - off-delay: input falling starts the delay, output drops when it elapses.
// - one-shot: a rising input while no pulse runs gives one pulse of the programmed width.
// - retriggerable: a rise during a pulse restarts a full-width pulse.
// - pulse train: while input is high, output toggles each period, repeating.
// - each step has a time setting 0 to 60000 hundredths, reset to 0.
// - in timer use the setting is a duration in hundredths of a second.
// - in counter use the setting itself is the integer count target.
// - each of the ten steps has its own internal result line.
// - step result lines can be picked as inputs of other steps.
// - step results leave the block only through the five routed outputs.
// - each routed output has a source selector, reset to 0.
// - each routed output has a destination function code, reset to 100.
// - each digital output terminal can pick one of the five routed outputs.
// - source 0 keeps a routed output off; 1 to 10 pick that step.
// - processing runs every 2 ms and captures all step inputs together.
// - steps evaluate in ascending order; earlier results feed later ones.
// - all five routed outputs update together at the end of a cycle.
module ulst_top #(
    parameter                      CYCLE_CLKS = `ULST_CYCLE_CLKS,
    parameter                      DOUT_N     = 3
) (
    input  wire                                 CORE_CLK_I,
    input  wire                                 RST_N_I,
    input  wire [`ULST_STEPS-1:0]               STEP_LOGIC_I,
    input  wire [`ULST_STEPS*`ULST_SRC_W-1:0]   STEP_SRC_I,
    input  wire [`ULST_STEPS*`ULST_MODE_W-1:0]  STEP_TYPE_I,
    input  wire [`ULST_STEPS-1:0]               STEP_COUNT_I,
    input  wire [`ULST_STEPS*`ULST_TIME_W-1:0]  STEP_TIME_I,
    input  wire [`ULST_ROUTES*`ULST_SRC_W-1:0]  ROUTE_SRC_I,
    input  wire [`ULST_ROUTES*`ULST_DEST_W-1:0] ROUTE_DEST_I,
    input  wire [DOUT_N*`ULST_DSEL_W-1:0]       DOUT_SEL_I,
    output reg  [`ULST_ROUTES-1:0]              ROUTED_O,
    output reg  [`ULST_ROUTES*`ULST_DEST_W-1:0] ROUTE_DEST_O,
    output reg  [DOUT_N-1:0]                    DOUT_O,
    output reg                                  CYCLE_TICK_O
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam [31:0] TICK_LAST = CYCLE_CLKS - 1;

    // period in whole processing cycles, rounded to nearest
    function [`ULST_CNT_W-1:0] cycles_of;
        input [`ULST_TIME_W-1:0] t;
        reg   [31:0]             prod;
        begin
            prod      = ({16'h0000, t} * `ULST_UNIT_US + (`ULST_CYCLE_US / 2))
                        / `ULST_CYCLE_US;
            cycles_of = prod[`ULST_CNT_W-1:0];
        end
    endfunction

    // step input: own captured input, or a step result; lower steps give
    // their fresh result of this cycle, the rest last cycle's result
    function pick_input;
        input [`ULST_SRC_W-1:0]  s;
        input [`ULST_STEPS-1:0]  raw;
        input [`ULST_STEPS-1:0]  fresh;
        input [`ULST_STEPS-1:0]  old;
        input integer            idx;
        integer                  k;
        begin
            k = s;
            k = k - 1;
            if (s == `ULST_SRC_NONE || s > `ULST_SRC_MAX) begin
                pick_input = raw[idx];
            end else if (k < idx) begin
                pick_input = fresh[k];
            end else begin
                pick_input = old[k];
            end
        end
    endfunction

    // routed source: 0 or out of range keeps the output off
    function pick_route;
        input [`ULST_SRC_W-1:0] s;
        input [`ULST_STEPS-1:0] res;
        integer                 k;
        begin
            k = s;
            k = k - 1;
            if (s == `ULST_SRC_NONE || s > `ULST_SRC_MAX) begin
                pick_route = 1'b0;
            end else begin
                pick_route = res[k];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // 2 ms processing cycle divider
    // ------------------------------------------------------------
    reg  [31:0]                        div_reg;
    wire                               tick_w;

    assign tick_w = (div_reg == TICK_LAST);

    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_reg      <= 32'h00000000;
            CYCLE_TICK_O <= 1'b0;
        end else begin
            div_reg      <= tick_w ? 32'h00000000 : div_reg + 32'h00000001;
            CYCLE_TICK_O <= tick_w;
        end
    end

    // ------------------------------------------------------------
    // step chain
    // ------------------------------------------------------------
    reg  [`ULST_STEPS-1:0]             res_reg;
    reg  [`ULST_STEPS-1:0]             in_prev_reg;
    reg  [`ULST_STEPS*`ULST_CNT_W-1:0] cnt_reg;
    wire [`ULST_STEPS-1:0]             res_next;
    wire [`ULST_STEPS-1:0]             in_next;
    wire [`ULST_STEPS*`ULST_CNT_W-1:0] cnt_next;

    genvar gi;
    generate
        for (gi = 0; gi < `ULST_STEPS; gi = gi + 1) begin : g_step
            wire [`ULST_TIME_W-1:0] time_w;
            wire [`ULST_CNT_W-1:0]  period_w;

            assign time_w = STEP_TIME_I[gi*`ULST_TIME_W +: `ULST_TIME_W];
            // counters take the setting as-is; timers convert to cycles
            assign period_w = STEP_COUNT_I[gi] ?
                              {{(`ULST_CNT_W-`ULST_TIME_W){1'b0}}, time_w} :
                              cycles_of(time_w);

            // feedback from higher steps uses last cycle's value, which
            // avoids a combinational loop through the chain
            assign in_next[gi] = pick_input(STEP_SRC_I[gi*`ULST_SRC_W +: `ULST_SRC_W],
                                            STEP_LOGIC_I, res_next, res_reg,
                                            gi);

            ulst_step u_step (
                .mode_i     (STEP_TYPE_I[gi*`ULST_MODE_W +: `ULST_MODE_W]),
                .count_en_i (STEP_COUNT_I[gi]),
                .period_i   (period_w),
                .in_i       (in_next[gi]),
                .in_prev_i  (in_prev_reg[gi]),
                .out_prev_i (res_reg[gi]),
                .cnt_i      (cnt_reg[gi*`ULST_CNT_W +: `ULST_CNT_W]),
                .out_o      (res_next[gi]),
                .cnt_o      (cnt_next[gi*`ULST_CNT_W +: `ULST_CNT_W])
            );
        end
    endgenerate

    // all step state advances together, once per processing cycle
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            res_reg     <= {`ULST_STEPS{1'b0}};
            in_prev_reg <= {`ULST_STEPS{1'b0}};
            cnt_reg     <= {(`ULST_STEPS*`ULST_CNT_W){1'b0}};
        end else if (tick_w) begin
            res_reg     <= res_next;
            in_prev_reg <= in_next;
            cnt_reg     <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // routed logic outputs
    // ------------------------------------------------------------
    reg  [`ULST_ROUTES-1:0]            route_next;
    integer                            ri;

    always @* begin
        route_next = {`ULST_ROUTES{1'b0}};
        for (ri = 0; ri < `ULST_ROUTES; ri = ri + 1) begin
            route_next[ri] = pick_route(ROUTE_SRC_I[ri*`ULST_SRC_W +: `ULST_SRC_W],
                                        res_next);
        end
    end

    // only the routed copies leave the block; raw step results stay inside
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ROUTED_O     <= {`ULST_ROUTES{1'b0}};
            ROUTE_DEST_O <= {`ULST_ROUTES{`ULST_DEST_RST}};
        end else if (tick_w) begin
            ROUTED_O     <= route_next;
            ROUTE_DEST_O <= ROUTE_DEST_I;
        end
    end

    // ------------------------------------------------------------
    // general-purpose digital output terminals
    // ------------------------------------------------------------
    reg  [DOUT_N-1:0]                  dout_next;
    reg  [`ULST_DSEL_W-1:0]            dsel;
    integer                            di;

    always @* begin
        dout_next = {DOUT_N{1'b0}};
        dsel      = `ULST_DSEL_NONE;
        for (di = 0; di < DOUT_N; di = di + 1) begin
            dsel = DOUT_SEL_I[di*`ULST_DSEL_W +: `ULST_DSEL_W];
            if (dsel != `ULST_DSEL_NONE && dsel <= `ULST_DSEL_MAX) begin
                dout_next[di] = ROUTED_O[dsel - 3'h1];
            end
        end
    end

    // terminals follow the routed outputs one clock later
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DOUT_O <= {DOUT_N{1'b0}};
        end else begin
            DOUT_O <= dout_next;
        end
    end

endmodule // ulst_top

// File: shared/ulst_defs.vh
// constants shared by the user logic step timer and router
`ifndef ULST_DEFS_VH
`define ULST_DEFS_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define ULST_STEPS        10
`define ULST_ROUTES       5
`define ULST_TIME_W       16
`define ULST_CNT_W        19
`define ULST_SRC_W        4
`define ULST_MODE_W       3
`define ULST_DEST_W       11
`define ULST_DSEL_W       3

// ----------------------------------------------------------------
// timer type codes
// ----------------------------------------------------------------
`define ULST_MODE_NONE    3'h0
`define ULST_MODE_ON_DLY  3'h1
`define ULST_MODE_OFF_DLY 3'h2
`define ULST_MODE_ONESHOT 3'h3
`define ULST_MODE_RETRIG  3'h4
`define ULST_MODE_PULSE   3'h5

// ----------------------------------------------------------------
// reset values and selector codes
// ----------------------------------------------------------------
`define ULST_SRC_NONE     4'h0
`define ULST_SRC_MAX      4'hA
`define ULST_DEST_RST     11'h064
`define ULST_DSEL_NONE    3'h0
`define ULST_DSEL_MAX     3'h5

// ----------------------------------------------------------------
// timing: processing cycle, setting unit, core clock
// ----------------------------------------------------------------
`define ULST_CYCLE_US     2000
`define ULST_UNIT_US      10000
`define ULST_CLK_MHZ      10
`define ULST_CYCLE_CLKS   (`ULST_CYCLE_US * `ULST_CLK_MHZ)

`endif

// File: verilog/ulst_step.v
// one logic step: general-purpose timer or edge counter, next-state logic
`timescale 1ns/100ps
`include "ulst_defs.vh"

module ulst_step (
    input  wire [`ULST_MODE_W-1:0] mode_i,
    input  wire                    count_en_i,
    input  wire [`ULST_CNT_W-1:0]  period_i,
    input  wire                    in_i,
    input  wire                    in_prev_i,
    input  wire                    out_prev_i,
    input  wire [`ULST_CNT_W-1:0]  cnt_i,
    output reg                     out_o,
    output reg  [`ULST_CNT_W-1:0]  cnt_o
);

    wire                   rise_w;
    wire [`ULST_CNT_W-1:0] inc_w;

    assign rise_w = in_i & ~in_prev_i;
    // saturating increment keeps long-held inputs from wrapping the count
    assign inc_w  = (cnt_i == {`ULST_CNT_W{1'b1}}) ? cnt_i : cnt_i + 1'b1;

    always @* begin
        out_o = 1'b0;
        cnt_o = cnt_i;
        if (count_en_i) begin
            // count rising edges up to the target; target is the raw setting
            if (rise_w && cnt_i < period_i) begin
                cnt_o = inc_w;
            end
            out_o = (cnt_o >= period_i);
        end else begin
            case (mode_i)
                `ULST_MODE_NONE: begin
                    out_o = in_i;
                    cnt_o = {`ULST_CNT_W{1'b0}};
                end
                `ULST_MODE_ON_DLY: begin
                    if (!in_i) begin
                        cnt_o = {`ULST_CNT_W{1'b0}};
                        out_o = 1'b0;
                    end else begin
                        if (rise_w) begin
                            cnt_o = {`ULST_CNT_W{1'b0}};
                        end else if (cnt_i < period_i) begin
                            cnt_o = inc_w;
                        end
                        out_o = (cnt_o >= period_i);
                    end
                end
                `ULST_MODE_OFF_DLY: begin
                    if (in_i) begin
                        cnt_o = {`ULST_CNT_W{1'b0}};
                        out_o = 1'b1;
                    end else if (out_prev_i) begin
                        cnt_o = in_prev_i ? {`ULST_CNT_W{1'b0}} : inc_w;
                        out_o = (cnt_o < period_i);
                    end
                end
                `ULST_MODE_ONESHOT,
                `ULST_MODE_RETRIG: begin
                    if (rise_w && (!out_prev_i || mode_i == `ULST_MODE_RETRIG)) begin
                        cnt_o = {`ULST_CNT_W{1'b0}};
                        out_o = (period_i != {`ULST_CNT_W{1'b0}});
                    end else if (out_prev_i) begin
                        cnt_o = inc_w;
                        out_o = (cnt_o < period_i);
                    end
                end
                `ULST_MODE_PULSE: begin
                    if (!in_i) begin
                        cnt_o = {`ULST_CNT_W{1'b0}};
                        out_o = 1'b0;
                    end else if (rise_w) begin
                        cnt_o = {`ULST_CNT_W{1'b0}};
                        out_o = 1'b1;
                    end else if (inc_w >= period_i) begin
                        cnt_o = {`ULST_CNT_W{1'b0}};
                        out_o = ~out_prev_i;
                    end else begin
                        cnt_o = inc_w;
                        out_o = out_prev_i;
                    end
                end
                default: begin
                    out_o = 1'b0;
                    cnt_o = {`ULST_CNT_W{1'b0}};
                end
            endcase
        end
    end

endmodule // ulst_step

// File: bench/ulst_properties.sv
// concurrent checks on the routed outputs of the step timer block
`timescale 1ns/100ps
`include "ulst_defs.vh"

module ulst_chk #(
    parameter CYCLE_CLKS = 4,
    parameter DOUT_N     = 3
) (
    input wire                                 CORE_CLK_I,
    input wire                                 RST_N_I,
    input wire [`ULST_ROUTES*`ULST_SRC_W-1:0]  ROUTE_SRC_I,
    input wire [`ULST_ROUTES*`ULST_DEST_W-1:0] ROUTE_DEST_I,
    input wire [DOUT_N*`ULST_DSEL_W-1:0]       DOUT_SEL_I,
    input wire [`ULST_ROUTES-1:0]              ROUTED_O,
    input wire [`ULST_ROUTES*`ULST_DEST_W-1:0] ROUTE_DEST_O,
    input wire [DOUT_N-1:0]                    DOUT_O,
    input wire                                 CYCLE_TICK_O
);
    reg [31:0] gap_reg;
    reg        seen_reg;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            gap_reg  <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= CYCLE_TICK_O ? 32'h1 : gap_reg + 32'h1;
            seen_reg <= seen_reg | CYCLE_TICK_O;
        end
    end
    function automatic [DOUT_N-1:0] dout_f(input [DOUT_N*3-1:0] s, input [4:0] r);
        integer j;
        reg [2:0] v;
        begin
            for (j = 0; j < DOUT_N; j = j + 1) begin
                v = s[j*3 +: 3];
                dout_f[j] = (v >= 3'h1 && v <= 3'h5) ? r[v-1] : 1'b0;
            end
        end
    endfunction
    // tick edge vs tick pulse is one clock apart at most, so windows allow both
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_tick_gap; CYCLE_TICK_O && seen_reg |-> gap_reg == CYCLE_CLKS; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
    property p_tick_one; CYCLE_TICK_O |=> !CYCLE_TICK_O; endproperty
    a_tick_one: assert property (p_tick_one) else $error("tick wider than a clock");
    property p_routed_tick; $changed(ROUTED_O) |-> ##[0:1] CYCLE_TICK_O; endproperty
    a_routed_tick: assert property (p_routed_tick) else $error("routed off tick");
    property p_dest_tick; $changed(ROUTE_DEST_O) |-> ##[0:1] CYCLE_TICK_O; endproperty
    a_dest_tick: assert property (p_dest_tick) else $error("dest off tick");
    property p_dest_copy;
        $rose(CYCLE_TICK_O) |->
            ROUTE_DEST_O == $past(ROUTE_DEST_I) || ROUTE_DEST_O == $past(ROUTE_DEST_I, 2);
    endproperty
    a_dest_copy: assert property (p_dest_copy) else $error("dest not copied");
    property p_rst_vals;
        $rose(RST_N_I) |-> ROUTE_DEST_O == {`ULST_ROUTES{`ULST_DEST_RST}} && ROUTED_O == 5'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    property p_src_off;
        CYCLE_TICK_O && ($past(ROUTE_SRC_I[3:0]) == 4'h0 || $past(ROUTE_SRC_I[3:0]) > 4'hA)
            && ($past(ROUTE_SRC_I[3:0], 2) == 4'h0 || $past(ROUTE_SRC_I[3:0], 2) > 4'hA)
            |-> !ROUTED_O[0];
    endproperty
    a_src_off: assert property (p_src_off) else $error("unselected route active");
    property p_dout; DOUT_O == dout_f($past(DOUT_SEL_I), $past(ROUTED_O)); endproperty
    a_dout: assert property (p_dout) else $error("terminal output wrong");
    c_route: cover property (CYCLE_TICK_O && ROUTED_O != 5'h0);
    c_dout: cover property ($changed(DOUT_O));
    c_rise: cover property ($rose(ROUTED_O[0]));
endmodule // ulst_chk

bind ulst_top ulst_chk #(.CYCLE_CLKS(CYCLE_CLKS), .DOUT_N(DOUT_N)) u_chk (
    .CORE_CLK_I   (CORE_CLK_I),
    .RST_N_I      (RST_N_I),
    .ROUTE_SRC_I  (ROUTE_SRC_I),
    .ROUTE_DEST_I (ROUTE_DEST_I),
    .DOUT_SEL_I   (DOUT_SEL_I),
    .ROUTED_O     (ROUTED_O),
    .ROUTE_DEST_O (ROUTE_DEST_O),
    .DOUT_O       (DOUT_O),
    .CYCLE_TICK_O (CYCLE_TICK_O)
);

// File: bench/ulst_seq_model.sv
// far-side sink: sequence processor taking routed outputs once a cycle
`timescale 1ns/100ps
`include "ulst_defs.vh"

module ulst_seq_model (
    input  wire                                 clk_i,
    input  wire                                 rst_n_i,
    input  wire                                 tick_i,
    input  wire [`ULST_ROUTES-1:0]              routed_i,
    input  wire [`ULST_ROUTES*`ULST_DEST_W-1:0] dest_i,
    output reg  [`ULST_ROUTES-1:0]              cmd_o,
    output reg  [`ULST_ROUTES*`ULST_DEST_W-1:0] func_o
);
    // latching on the tick pulse only, so a glitch between cycles never reaches it
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_o  <= 5'h0;
            func_o <= 55'h0;
        end else if (tick_i) begin
            cmd_o  <= routed_i;
            func_o <= dest_i;
        end
    end
endmodule // ulst_seq_model

// File: bench/tb.sv
// self-checking bench for the step timer and router
`timescale 1ns/100ps
`include "ulst_defs.vh"

module tb;
    reg          clk;
    reg          rst_n;
    reg  [9:0]   logic_in;
    reg  [39:0]  src;
    reg  [29:0]  typ;
    reg  [9:0]   cnt_en;
    reg  [159:0] tim;
    reg  [19:0]  rsrc;
    reg  [54:0]  rdest;
    reg  [8:0]   dsel;
    wire [4:0]   routed;
    wire [54:0]  dest_o;
    wire [2:0]   dout;
    wire         tick;
    wire [4:0]   cmd;
    wire [54:0]  func;
    integer      n_mismatch;
    integer      checks_done;
    integer      r;
    integer      t;
    integer      k;
    reg  [51:0]  rows [0:7];
    reg  [9:0]   pat;
    reg  [4:0]   er;
    reg          prv;

    ulst_top #(.CYCLE_CLKS(4), .DOUT_N(3)) uut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .STEP_LOGIC_I(logic_in), .STEP_SRC_I(src),
        .STEP_TYPE_I(typ), .STEP_COUNT_I(cnt_en), .STEP_TIME_I(tim), .ROUTE_SRC_I(rsrc),
        .ROUTE_DEST_I(rdest), .DOUT_SEL_I(dsel), .ROUTED_O(routed), .ROUTE_DEST_O(dest_o),
        .DOUT_O(dout), .CYCLE_TICK_O(tick));
    ulst_seq_model u_seq (.clk_i(clk), .rst_n_i(rst_n), .tick_i(tick), .routed_i(routed),
        .dest_i(dest_o), .cmd_o(cmd), .func_o(func));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task chk_vec(input string nm, input [54:0] e, input [54:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                $display("ERROR %0s expected %h seen %h", nm, e, g);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // bounded wait for the cycle pulse; returns just after the clock that shows it
    task wait_tick;
        integer n;
        begin
            n = 0;
            @(posedge clk);
            #1;
            while (tick !== 1'b1 && n < 10) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (tick !== 1'b1) begin
                $display("ERROR tick expected 1 seen %b", tick);
                n_mismatch = n_mismatch + 1;
                finish_test;
            end
        end
    endtask
    task do_reset;
        begin
            rst_n = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            chk_vec("rst_dest", {5{11'h064}}, dest_o);
            chk_vec("rst_out", 55'h0, {47'h0, routed, dout});
            rst_n = 1'b1;
        end
    endtask
    function automatic fsel(input [3:0] s, input [9:0] p);
        fsel = (s >= 4'h1 && s <= 4'hA) ? p[s-1] : 1'b0;
    endfunction
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        checks_done = 0;
        rst_n = 1'b0;
        logic_in = 10'h000;
        src = 40'h0;
        typ = 30'h0;
        cnt_en = 10'h000;
        tim = 160'h0;
        rsrc = 20'h00001;
        rdest = {5{11'h064}};
        dsel = 9'h001;
        // row: counter enable, type, time, input per tick, expected per tick
        rows[0] = {1'b0, 3'h0, 16'h0001, 16'h0F3A, 16'h0F3A};
        rows[1] = {1'b0, 3'h1, 16'h0001, 16'hFEFF, 16'hC0E0};
        rows[2] = {1'b0, 3'h2, 16'h0001, 16'h0403, 16'hFC7F};
        rows[3] = {1'b0, 3'h3, 16'h0001, 16'hFC0B, 16'h7C1F};
        rows[4] = {1'b0, 3'h4, 16'h0001, 16'hFC0B, 16'h7CFF};
        rows[5] = {1'b0, 3'h5, 16'h0001, 16'h1FFF, 16'h1C1F};
        rows[6] = {1'b0, 3'h6, 16'h0001, 16'hFFFF, 16'h0000};
        rows[7] = {1'b1, 3'h0, 16'h0002, 16'h002A, 16'hFFF8};
        for (r = 0; r < 8; r = r + 1) begin
            {cnt_en[0], typ[2:0], tim[15:0]} = rows[r][51:32];
            logic_in[0] = rows[r][16];
            do_reset;
            for (t = 0; t < 16; t = t + 1) begin
                wait_tick;
                chk_vec("step", {54'h0, rows[r][t]}, {54'h0, routed[0]});
                logic_in[0] = rows[r][16 + (t + 1) % 16];
            end
            $display("test row %0d done", r);
        end
        cnt_en = 10'h000;
        typ = 30'h0;
        for (k = 0; k < 32; k = k + 1) begin
            pat = (k < 16) ? 10'h2B5 : 10'h14A;
            logic_in = pat;
            rsrc = {4'hA, 4'h7, 4'h3, 4'h2, k[3:0]};
            er = {pat[9], pat[6], pat[2], pat[1], fsel(k[3:0], pat)};
            wait_tick;
            chk_vec("routed", {50'h0, er}, {50'h0, routed});
        end
        $display("test routing done");
        for (k = 0; k < 8; k = k + 1) begin
            dsel = {3'h5, 3'h7 - k[2:0], k[2:0]};
            @(posedge clk);
            #1;
            chk_vec("dout", {52'h0, er[4], fsel({1'b0, 3'h7 - k[2:0]}, {5'h0, er}),
                fsel({1'b0, k[2:0]}, {5'h0, er})}, {52'h0, dout});
        end
        $display("test terminals done");
        src = {28'h0, 4'h4, 4'h1, 4'h0};
        rsrc = 20'h00032;
        logic_in = 10'h000;
        wait_tick;
        prv = 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
            logic_in = {6'h0, k[1], 2'h0, k[0]};
            wait_tick;
            chk_vec("chain", {53'h0, prv, k[0]}, {53'h0, routed[1:0]});
            prv = k[1];
        end
        $display("test order done");
        rdest = {11'h3E8, 11'h001, 11'h438, 11'h064, 11'h7FF};
        wait_tick;
        chk_vec("dest", rdest, dest_o);
        @(posedge clk);
        #1;
        chk_vec("far_func", rdest, func);
        chk_vec("far_cmd", 55'h01, {50'h0, cmd});
        $display("test far side done");
        finish_test;
    end
endmodule // tb
